// File: common/wdog_psm_pkg.sv
package wdog_psm_pkg;

    // ==========================================================
    // clocking and derived tick rates
    // ==========================================================
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned SLOW_HZ          = 32_768;
    // divide down rounds toward the faster side; error is under 0.1 %
    localparam int unsigned TICK_DIV         = CLK_HZ / SLOW_HZ;
    localparam logic [10:0] TICK_LAST        = 11'(TICK_DIV - 1);
    localparam int unsigned ALARM_HOLD_MS    = 250;
    localparam int unsigned ALARM_HOLD_TICKS =
        ALARM_HOLD_MS * SLOW_HZ / 1000;
    localparam int          HOLD_W           = 14;
    localparam logic [1:0]  FILT_LAST        = 2'h3;

    // ==========================================================
    // watchdog counter
    // ==========================================================
    localparam int          WDOG_CNT_W       = 16;
    localparam logic [3:0]  PRE_MAX          = 4'h7;
    localparam logic [4:0]  WDOG_BASE_SHIFT  = 5'h09;

    // ==========================================================
    // register addresses, reset values and bit positions
    // ==========================================================
    localparam logic [7:0]  WATCHDOG_CONTROL_ADDR       = 8'hc0;
    localparam logic [7:0]  SUPPLY_MONITOR_CONTROL_ADDR      = 8'hdf;
    localparam logic [7:0]  WATCHDOG_CONTROL_RESET      = 8'h10;
    localparam logic [7:0]  SUPPLY_MONITOR_CONTROL_RESET     = 8'hde;
    localparam logic [7:0]  RDATA_UNMAPPED   = 8'h00;

    localparam int          WD_PRE_HI        = 7;
    localparam int          WD_PRE_LO        = 4;
    localparam int          WD_IRQ_SEL       = 3;
    localparam int          WD_FLAG          = 2;
    localparam int          WD_EN            = 1;
    localparam int          WD_UNLOCK        = 0;

    localparam int          PSM_DOK          = 7;
    localparam int          PSM_AOK          = 6;
    localparam int          PSM_ALARM        = 5;
    localparam int          PSM_DTRIP_HI     = 4;
    localparam int          PSM_DTRIP_LO     = 3;
    localparam int          PSM_ATRIP_HI     = 2;
    localparam int          PSM_ATRIP_LO     = 1;
    localparam int          PSM_EN           = 0;

    // ==========================================================
    // write-unlock sequence
    // ==========================================================
    typedef enum {UNLOCK_IDLE, UNLOCK_OWN, UNLOCK_ARMED} unlock_type;

endpackage

// File: hw/wdog_counter.sv
`timescale 1ns/1ps
module wdog_counter
    import wdog_psm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        tick,
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic [3:0]  prescale,
    // event
    output logic             expire
);

    logic [WDOG_CNT_W-1:0] cnt_r;
    logic [3:0]            pre_eff;
    logic [16:0]           span_w;
    logic                  hit_w;

    // ==========================================================
    // timeout span
    // ==========================================================
    // reserved prescale codes saturate so the span never overflows
    assign pre_eff = (prescale > PRE_MAX) ? PRE_MAX : prescale;
    assign span_w  = 17'h1 << ({1'b0, pre_eff} + WDOG_BASE_SHIFT);
    assign hit_w   = ({1'b0, cnt_r} == (span_w - 17'h1));

    // ==========================================================
    // counter, one step per slow tick
    // ==========================================================
    always_ff @(posedge clk)
    begin
        expire <= 1'b0;
        if (!rst_n || clear || !run)
        begin
            cnt_r <= '0;
        end
        else if (tick)
        begin
            if (hit_w)
            begin
                cnt_r  <= '0;
                expire <= 1'b1;
            end
            else
            begin
                cnt_r <= cnt_r + 16'h1;
            end
        end
    end

endmodule

// File: hw/supply_filter.sv
`timescale 1ns/1ps
module supply_filter
    import wdog_psm_pkg::*;
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // comparator
    input  wire logic  tick,
    input  wire logic  raw,
    output logic       filtered
);

    logic [1:0] cnt_r;

    // ==========================================================
    // change is accepted only after a run of equal slow samples
    // ==========================================================
    // a pulse shorter than the run never reaches the alarm logic
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            filtered <= 1'b1;
            cnt_r    <= '0;
        end
        else if (tick)
        begin
            if (raw == filtered)
            begin
                cnt_r <= '0;
            end
            else if (cnt_r == FILT_LAST)
            begin
                filtered <= raw;
                cnt_r    <= '0;
            end
            else
            begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end

endmodule

// File: hw/watchdog_and_supply_monitor.sv
`timescale 1ns/1ps
module watchdog_and_supply_monitor
    import wdog_psm_pkg::*;
#(
    parameter int unsigned HOLD_TICKS = ALARM_HOLD_TICKS
)
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // register port from the core
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic        SFR_WE,
    input  wire logic        SFR_RE,
    input  wire logic        INSTR_END,
    output logic      [7:0]  SFR_RDATA,
    // supply comparators
    input  wire logic        DIGITAL_SUPPLY_OK,
    input  wire logic        ANALOG_SUPPLY_OK,
    output logic      [1:0]  DIGITAL_TRIP_SEL,
    output logic      [1:0]  ANALOG_TRIP_SEL,
    // interrupt enable bit held in the core
    input  wire logic        SUPPLY_IRQ_ENABLE,
    // requests to the core
    output logic             WDOG_RESET_REQ,
    output logic             WDOG_NMI_REQ,
    output logic             SUPPLY_IRQ_REQ
);

    // ==========================================================
    // state
    // ==========================================================
    logic [10:0]        div_r;
    logic               tick_r;
    unlock_type         unlock_r;
    unlock_type         unlock_nxt;
    logic [3:0]         prescale_r;
    logic               irq_sel_r;
    logic               wd_flag_r;
    logic               wd_en_r;
    logic [1:0]         dtrip_r;
    logic [1:0]         atrip_r;
    logic               mon_en_r;
    logic               alarm_r;
    logic               alarm_nxt;
    logic [HOLD_W-1:0]  hold_r;
    logic               dig_ok_f;
    logic               ana_ok_f;
    logic               expire_w;

    // ==========================================================
    // decode
    // ==========================================================
    logic wd_hit_w;
    logic psm_hit_w;
    logic commit_w;
    logic kick_w;
    logic wd_reset_w;
    logic wd_irq_w;
    logic supply_low_w;
    logic supply_irq_nxt;
    logic psm_irq_rise_w;
    logic hold_done_w;
    logic sw_alarm_set_w;
    logic sw_alarm_clr_w;
    logic [7:0] wd_read_w;
    logic [7:0] psm_read_w;
    logic [7:0] rdata_nxt;

    assign wd_hit_w  = SFR_WE && (SFR_ADDR == WATCHDOG_CONTROL_ADDR);
    assign psm_hit_w = SFR_WE && (SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR);
    // only the write right after the arming instruction lands
    assign commit_w  = wd_hit_w && (unlock_r == UNLOCK_ARMED);
    assign kick_w    = commit_w && SFR_WDATA[WD_EN];
    assign wd_reset_w = expire_w && !irq_sel_r;
    assign wd_irq_w   = expire_w && irq_sel_r;

    // monitor enable masks the comparators before they reach the alarm
    assign supply_low_w = mon_en_r && (!dig_ok_f || !ana_ok_f);
    assign hold_done_w  = (hold_r == HOLD_W'(HOLD_TICKS - 1)) && tick_r;
    assign sw_alarm_set_w = psm_hit_w && SFR_WDATA[PSM_ALARM];
    // a clear attempt while any supply is low is dropped
    assign sw_alarm_clr_w = psm_hit_w && !SFR_WDATA[PSM_ALARM]
                          && dig_ok_f && ana_ok_f;
    // set sources win over both clear paths
    assign alarm_nxt = supply_low_w || sw_alarm_set_w
                     || (alarm_r && !hold_done_w && !sw_alarm_clr_w);
    assign supply_irq_nxt = alarm_nxt && mon_en_r
                          && SUPPLY_IRQ_ENABLE;
    assign psm_irq_rise_w = supply_irq_nxt && !SUPPLY_IRQ_REQ;

    assign wd_read_w  = {prescale_r, irq_sel_r, wd_flag_r, wd_en_r,
                         unlock_r != UNLOCK_IDLE};
    // comparator bits are the live inputs, not the filtered copies
    assign psm_read_w = {DIGITAL_SUPPLY_OK, ANALOG_SUPPLY_OK,
                         alarm_r, dtrip_r, atrip_r, mon_en_r};
    assign rdata_nxt  = (SFR_ADDR == WATCHDOG_CONTROL_ADDR)  ? wd_read_w  :
                        (SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR) ? psm_read_w :
                        RDATA_UNMAPPED;

    // ==========================================================
    // slow tick divider
    // ==========================================================
    always_ff @(posedge CLK)
    begin
        if (!RST_N || div_r == TICK_LAST)
        begin
            div_r <= '0;
        end
        else
        begin
            div_r <= div_r + 11'h1;
        end
    end

    always_ff @(posedge CLK)
    begin
        tick_r <= RST_N && (div_r == TICK_LAST);
    end

    // ==========================================================
    // unlock sequence
    // ==========================================================
    // the arming write's own instruction must end before the window opens
    always_comb
    begin
        unlock_nxt = unlock_r;
        unique case (unlock_r)
            UNLOCK_IDLE:
            begin
                if (wd_hit_w && SFR_WDATA[WD_UNLOCK])
                    unlock_nxt = INSTR_END ? UNLOCK_ARMED : UNLOCK_OWN;
            end
            UNLOCK_OWN:
            begin
                if (INSTR_END)
                    unlock_nxt = UNLOCK_ARMED;
            end
            UNLOCK_ARMED:
            begin
                if (wd_hit_w || INSTR_END)
                    unlock_nxt = UNLOCK_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            unlock_r <= UNLOCK_IDLE;
        else
            unlock_r <= unlock_nxt;
    end

    // ==========================================================
    // watchdog control register
    // ==========================================================
    // hardware clears of the enable bit win over a kick in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            prescale_r <= WATCHDOG_CONTROL_RESET[WD_PRE_HI:WD_PRE_LO];
            irq_sel_r  <= WATCHDOG_CONTROL_RESET[WD_IRQ_SEL];
            wd_flag_r  <= WATCHDOG_CONTROL_RESET[WD_FLAG];
            wd_en_r    <= WATCHDOG_CONTROL_RESET[WD_EN];
        end
        else
        begin
            if (commit_w)
            begin
                prescale_r <= SFR_WDATA[WD_PRE_HI:WD_PRE_LO];
                irq_sel_r  <= SFR_WDATA[WD_IRQ_SEL];
                wd_en_r    <= SFR_WDATA[WD_EN];
            end
            if (wd_reset_w || psm_irq_rise_w)
                wd_en_r <= 1'b0;
            // a watchdog reset leaves the flag standing; set beats clear
            if (expire_w)
                wd_flag_r <= 1'b1;
            else if (commit_w && !SFR_WDATA[WD_FLAG])
                wd_flag_r <= 1'b0;
        end
    end

    wdog_counter u_wdog_counter
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .tick     (tick_r),
        .clear    (kick_w),
        .run      (wd_en_r),
        .prescale (prescale_r),
        .expire   (expire_w)
    );

    // ==========================================================
    // watchdog requests to the core
    // ==========================================================
    // the interrupt is a non-maskable level: no global enable gates it
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            WDOG_RESET_REQ <= 1'b0;
            WDOG_NMI_REQ   <= 1'b0;
        end
        else
        begin
            WDOG_RESET_REQ <= wd_reset_w;
            WDOG_NMI_REQ   <= wd_irq_w
                           || (WDOG_NMI_REQ && wd_flag_r);
        end
    end

    // ==========================================================
    // supply monitor register
    // ==========================================================
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            dtrip_r  <= SUPPLY_MONITOR_CONTROL_RESET[PSM_DTRIP_HI:PSM_DTRIP_LO];
            atrip_r  <= SUPPLY_MONITOR_CONTROL_RESET[PSM_ATRIP_HI:PSM_ATRIP_LO];
            mon_en_r <= SUPPLY_MONITOR_CONTROL_RESET[PSM_EN];
        end
        else if (psm_hit_w)
        begin
            dtrip_r  <= SFR_WDATA[PSM_DTRIP_HI:PSM_DTRIP_LO];
            atrip_r  <= SFR_WDATA[PSM_ATRIP_HI:PSM_ATRIP_LO];
            mon_en_r <= SFR_WDATA[PSM_EN];
        end
    end

    // trip codes go out unchanged; the comparator owns the thresholds
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            DIGITAL_TRIP_SEL <= SUPPLY_MONITOR_CONTROL_RESET[PSM_DTRIP_HI:PSM_DTRIP_LO];
            ANALOG_TRIP_SEL  <= SUPPLY_MONITOR_CONTROL_RESET[PSM_ATRIP_HI:PSM_ATRIP_LO];
        end
        else
        begin
            DIGITAL_TRIP_SEL <= dtrip_r;
            ANALOG_TRIP_SEL  <= atrip_r;
        end
    end

    // ==========================================================
    // glitch filters
    // ==========================================================
    supply_filter u_dig_filter
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .tick     (tick_r),
        .raw      (DIGITAL_SUPPLY_OK),
        .filtered (dig_ok_f)
    );

    supply_filter u_ana_filter
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .tick     (tick_r),
        .raw      (ANALOG_SUPPLY_OK),
        .filtered (ana_ok_f)
    );

    // ==========================================================
    // alarm flag and hold timer
    // ==========================================================
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            alarm_r <= SUPPLY_MONITOR_CONTROL_RESET[PSM_ALARM];
        else
            alarm_r <= alarm_nxt;
    end

    // hold runs only while the alarm stands and no supply is low with the monitor enabled
    always_ff @(posedge CLK)
    begin
        if (!RST_N || !alarm_r || supply_low_w)
            hold_r <= '0;
        else if (tick_r)
            hold_r <= hold_r + HOLD_W'(1);
    end

    // ==========================================================
    // register read and supply interrupt
    // ==========================================================
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            SFR_RDATA      <= RDATA_UNMAPPED;
            SUPPLY_IRQ_REQ <= 1'b0;
        end
        else
        begin
            if (SFR_RE)
                SFR_RDATA <= rdata_nxt;
            SUPPLY_IRQ_REQ <= supply_irq_nxt;
        end
    end

endmodule

// File: testbench/wdog_psm_checker.sv
`timescale 1ns/1ps
module wdog_psm_checker
    import wdog_psm_pkg::*;
#(
    parameter int unsigned HOLD_TICKS = ALARM_HOLD_TICKS
)
(
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST_N,
    // register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_WE,
    input wire logic       SFR_RE,
    input wire logic       INSTR_END,
    input wire logic [7:0] SFR_RDATA,
    // supply side
    input wire logic       DIGITAL_SUPPLY_OK,
    input wire logic       ANALOG_SUPPLY_OK,
    input wire logic [1:0] DIGITAL_TRIP_SEL,
    input wire logic [1:0] ANALOG_TRIP_SEL,
    input wire logic       SUPPLY_IRQ_ENABLE,
    // requests
    input wire logic       WDOG_RESET_REQ,
    input wire logic       WDOG_NMI_REQ,
    input wire logic       SUPPLY_IRQ_REQ
);
    import wdog_psm_pkg::*;

    // ==========================================================
    // shared timing and access sequences
    // ==========================================================
    logic wd_wr;
    logic psm_wr;
    // watchdog writes may clear the flag, so nmi may only fall after one
    assign wd_wr  = SFR_WE && SFR_ADDR == WATCHDOG_CONTROL_ADDR;
    assign psm_wr = SFR_WE && SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_psm_write;
        SFR_WE && SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR;
    endsequence
    sequence s_psm_read;
        SFR_RE && SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR;
    endsequence
    sequence s_stray_read;
        SFR_RE && SFR_ADDR != SUPPLY_MONITOR_CONTROL_ADDR && SFR_ADDR != WATCHDOG_CONTROL_ADDR;
    endsequence

    // ==========================================================
    // assertions
    // ==========================================================
    a_reset_values: assert property ($rose(RST_N) |->
        SFR_RDATA == 8'h00 && DIGITAL_TRIP_SEL == 2'h3 && !WDOG_NMI_REQ
        && ANALOG_TRIP_SEL == 2'h3 && !SUPPLY_IRQ_REQ)
        else $error("outputs not at reset values after reset");
    a_irq_gated: assert property (SUPPLY_IRQ_REQ |->
        $past(SUPPLY_IRQ_ENABLE))
        else $error("supply request without its enable");
    // trip outputs sit one register stage behind the stored field
    a_trip_follow: assert property (s_psm_write |=> ##1
        DIGITAL_TRIP_SEL == $past(SFR_WDATA[4:3], 2)
        && ANALOG_TRIP_SEL == $past(SFR_WDATA[2:1], 2))
        else $error("trip selects do not follow the write");
    a_trip_stable: assert property (!psm_wr |=> ##1
        $stable(DIGITAL_TRIP_SEL) && $stable(ANALOG_TRIP_SEL))
        else $error("trip selects moved without a write");
    a_live_status: assert property (s_psm_read |=>
        SFR_RDATA[7:6] == {$past(DIGITAL_SUPPLY_OK), $past(ANALOG_SUPPLY_OK)})
        else $error("status bits do not show the comparators");
    a_stray_read: assert property (s_stray_read |=>
        SFR_RDATA == RDATA_UNMAPPED)
        else $error("unmapped read returned data");
    a_reset_pulse: assert property (WDOG_RESET_REQ |=>
        !WDOG_RESET_REQ)
        else $error("watchdog reset request longer than one cycle");
    a_nmi_holds: assert property (WDOG_NMI_REQ && !wd_wr
        && !$past(wd_wr) |=> WDOG_NMI_REQ)
        else $error("watchdog interrupt dropped without a write");
endmodule

bind watchdog_and_supply_monitor wdog_psm_checker #(
    .HOLD_TICKS(HOLD_TICKS)
) chk (
    .CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .INSTR_END(INSTR_END),
    .SFR_RDATA(SFR_RDATA), .DIGITAL_SUPPLY_OK(DIGITAL_SUPPLY_OK),
    .ANALOG_SUPPLY_OK(ANALOG_SUPPLY_OK), .DIGITAL_TRIP_SEL(DIGITAL_TRIP_SEL),
    .ANALOG_TRIP_SEL(ANALOG_TRIP_SEL), .SUPPLY_IRQ_ENABLE(SUPPLY_IRQ_ENABLE),
    .WDOG_RESET_REQ(WDOG_RESET_REQ), .WDOG_NMI_REQ(WDOG_NMI_REQ),
    .SUPPLY_IRQ_REQ(SUPPLY_IRQ_REQ)
);

// File: testbench/core_model.sv
`timescale 1ns/1ps
module core_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // requests from the block
    input  wire logic       wdog_reset_req,
    input  wire logic       wdog_nmi_req,
    input  wire logic       supply_irq_req,
    // software view of the core
    input  wire logic       irq_on,
    output logic            supply_irq_enable,
    output logic [7:0]      rst_cnt,
    output logic [7:0]      psm_cnt,
    output logic            nmi_seen
);
    // ==========================================================
    // request bookkeeping
    // ==========================================================
    logic psm_q;
    // enable bit lives in the core's own register
    assign supply_irq_enable = irq_on;
    // a watchdog reset is counted, never fed back to the reset pin,
    // so the block's timeout flag survives it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rst_cnt  <= 8'h00;
            psm_cnt  <= 8'h00;
            psm_q    <= 1'b0;
            nmi_seen <= 1'b0;
        end
        else
        begin
            psm_q <= supply_irq_req;
            if (wdog_reset_req)
                rst_cnt <= rst_cnt + 8'h01;
            if (supply_irq_req && !psm_q)
                psm_cnt <= psm_cnt + 8'h01;
            if (wdog_nmi_req)
                nmi_seen <= 1'b1;
        end
    end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wdog_psm_pkg::*;

    // ==========================================================
    // signals, design and core model
    // ==========================================================
    logic       clk, rst_n, we, re, iend, dok, aok, irq_on, irq_en;
    logic       rst_req, nmi_req, irq_req, nmi_seen;
    logic [7:0] addr, wdata, rdata, rst_cnt, psm_cnt;
    logic [1:0] dsel, asel;
    int         error_cnt  = 0;
    int         num_checks = 0;

    // short hold keeps the release test within a dozen slow ticks
    watchdog_and_supply_monitor #(.HOLD_TICKS(8)) dut (
        .CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WE(we), .SFR_RE(re), .INSTR_END(iend), .SFR_RDATA(rdata),
        .DIGITAL_SUPPLY_OK(dok), .ANALOG_SUPPLY_OK(aok),
        .DIGITAL_TRIP_SEL(dsel), .ANALOG_TRIP_SEL(asel),
        .SUPPLY_IRQ_ENABLE(irq_en), .WDOG_RESET_REQ(rst_req),
        .WDOG_NMI_REQ(nmi_req), .SUPPLY_IRQ_REQ(irq_req));
    core_model core (
        .clk(clk), .rst_n(rst_n), .wdog_reset_req(rst_req),
        .wdog_nmi_req(nmi_req), .supply_irq_req(irq_req), .irq_on(irq_on),
        .supply_irq_enable(irq_en), .rst_cnt(rst_cnt), .psm_cnt(psm_cnt),
        .nmi_seen(nmi_seen));

    always #10 clk = ~clk;

    // ==========================================================
    // bus and compare helpers
    // ==========================================================
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one idle cycle between accesses: strobes never re-assert at once
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        we    = 1'b1;
        iend  = 1'b1;
        @(negedge clk);
        we    = 1'b0;
        iend  = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        re   = 1'b1;
        @(negedge clk);
        re   = 1'b0;
        check8(rdata, exp);
    endtask
    task automatic wait_irq(input logic lvl, input int lim);
        int n;
        n = 0;
        while (irq_req !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check8({7'h0, irq_req}, {7'h0, lvl});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic test_reset();
        rd(WATCHDOG_CONTROL_ADDR, WATCHDOG_CONTROL_RESET);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, SUPPLY_MONITOR_CONTROL_RESET);
        rd(8'h55, RDATA_UNMAPPED);
        check8({4'h0, dsel, asel}, 8'h0f);
        $display("test_reset done");
    endtask
    task automatic test_unlock();
        bus_wr(WATCHDOG_CONTROL_ADDR, 8'h36);
        rd(WATCHDOG_CONTROL_ADDR, 8'h10);
        bus_wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        bus_wr(WATCHDOG_CONTROL_ADDR, 8'h36);
        rd(WATCHDOG_CONTROL_ADDR, 8'h32);
        bus_wr(WATCHDOG_CONTROL_ADDR, 8'h01);
        bus_wr(8'h55, 8'h00);
        bus_wr(WATCHDOG_CONTROL_ADDR, 8'h00);
        rd(WATCHDOG_CONTROL_ADDR, 8'h32);
        $display("test_unlock done");
    endtask
    task automatic test_trip();
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(SUPPLY_MONITOR_CONTROL_ADDR, {3'h0, i[1:0], ~i[1:0], 1'b0});
            // the pins follow the stored field one cycle later
            @(negedge clk);
            check8({4'h0, dsel, asel}, {4'h0, i[1:0], ~i[1:0]});
        end
        $display("test_trip done");
    endtask
    task automatic test_alarm();
        bus_wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
        dok = 1'b0;
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'h41);
        wait_irq(1'b1, 10000);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'h61);
        bus_wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'h61);
        rd(WATCHDOG_CONTROL_ADDR, 8'h30);
        dok = 1'b1;
        // release needs filter plus hold, well over this span
        repeat (10000) @(negedge clk);
        check8({7'h0, irq_req}, 8'h01);
        wait_irq(1'b0, 15000);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1);
        check8(psm_cnt, 8'h01);
        $display("test_alarm done");
    endtask
    task automatic test_glitch();
        @(negedge clk);
        dok = 1'b0;
        // spans three slow ticks at most, one short of the filter run
        repeat (4000) @(negedge clk);
        dok = 1'b1;
        repeat (8000) @(negedge clk);
        check8({7'h0, irq_req}, 8'h00);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1);
        $display("test_glitch done");
    endtask
    task automatic test_disabled();
        bus_wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h00);
        aok = 1'b0;
        repeat (8000) @(negedge clk);
        check8({7'h0, irq_req}, 8'h00);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'h80);
        // alarm sets at once on enable, but the core's enable holds it back
        irq_on = 1'b0;
        bus_wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
        rd(SUPPLY_MONITOR_CONTROL_ADDR, 8'ha1);
        check8({7'h0, irq_req}, 8'h00);
        irq_on = 1'b1;
        wait_irq(1'b1, 4);
        aok = 1'b1;
        check8({rst_cnt[6:0], nmi_seen}, 8'h00);
        $display("test_disabled done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial
    begin
        clk    = 1'b0;
        rst_n  = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
        we     = 1'b0;
        re     = 1'b0;
        iend   = 1'b0;
        dok    = 1'b1;
        aok    = 1'b1;
        irq_on = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_unlock();
        test_trip();
        test_alarm();
        test_glitch();
        test_disabled();
        wrap_up();
    end
    // all scenarios take near 45k cycles; allow twice that
    initial
    begin
        #1_800_000;
        error_cnt++;
        wrap_up();
    end
endmodule
